// [rtl/fsbr_addr_req.sv]
// address request phase of the front side bus, device end
// assumes pins arrive asynchronous to clk_sys; bus pins are active low
`timescale 1ns/1ps
`default_nettype none
`include "fsbr_defines.svh"

module fsbr_addr_req #(
    parameter int HALF_CYC = `FSBR_HALF_CYC
) (
    input  wire  logic                  clk_sys,
    input  wire  logic                  srst,
    input  wire  fsbr_pkg::fsbr_addr_t  addr_lines_n_pin,
    output var   fsbr_pkg::fsbr_addr_t  addr_lines_n_drv,
    output logic                        addr_lines_oe_n,
    input  wire  fsbr_pkg::fsbr_req_t   req_type_n_pin,
    output var   fsbr_pkg::fsbr_req_t   req_type_n_drv,
    output logic                        req_type_oe_n,
    input  wire  logic                  address_valid_strobe_n_pin,
    output logic                        address_valid_strobe_n_drv,
    output logic                        address_valid_strobe_oe_n,
    input  wire  logic [1:0]            addr_source_strobes_n_pin,
    output logic [1:0]                  addr_source_strobes_n_drv,
    output logic                        addr_source_strobes_oe_n,
    input  wire  logic [1:0]            address_parity_pair_n_pin,
    output logic [1:0]                  address_parity_pair_n_drv,
    output logic                        address_parity_pair_oe_n,
    input  wire  logic                  addr_bit20_mask_in_n,
    input  wire  logic                  tx_valid,
    output logic                        tx_ready,
    input  wire  fsbr_pkg::fsbr_addr_t  tx_addr,
    input  wire  fsbr_pkg::fsbr_addr_t  tx_attr,
    input  wire  fsbr_pkg::fsbr_req_t   tx_req_a,
    input  wire  fsbr_pkg::fsbr_req_t   tx_req_b,
    output logic                        rx_start,
    output logic                        rx_valid,
    output var   fsbr_pkg::fsbr_addr_t  rx_addr,
    output var   fsbr_pkg::fsbr_addr_t  rx_attr,
    output var   fsbr_pkg::fsbr_req_t   rx_req_a,
    output var   fsbr_pkg::fsbr_req_t   rx_req_b,
    output logic                        rx_parity_err,
    output logic                        rx_protocol_err,
    output logic                        a20_mask_active
);
    generate
        if (HALF_CYC < 4 || HALF_CYC > 255) begin : g_chk
            $error("HALF_CYC must lie in 4..255");
        end
    endgenerate

    localparam logic [7:0] HALF = 8'(HALF_CYC);

    fsbr_pkg::fsbr_state_s st;
    fsbr_pkg::fsbr_state_s next_st;
    fsbr_pkg::fsbr_addr_t  tx_addr_m;
    fsbr_pkg::fsbr_addr_t  a_now;
    fsbr_pkg::fsbr_req_t   req_now;
    logic [1:0]            stb_fall;
    logic [1:0]            stb_rise;
    logic                  ads_fall;
    logic                  tx_sub2;

    fsbr_par_if #(.N(`FSBR_PAR_CH)) pif ();

    fsbr_parity_calc #(.N(`FSBR_PAR_CH)) u_par (
        .pif (pif.calc)
    );

    ////////////////////////////////////////////////////////////////////////////
    // parity lanes: transmit, received sub-phase 1, received sub-phase 2

    always_comb begin
        tx_addr_m = tx_addr;
        // mask forces bit 20 low before the address leaves
        tx_addr_m[`FSBR_A20_BIT] = tx_addr[`FSBR_A20_BIT] & ~st.a20_mask;
    end

    assign tx_sub2 = (st.tx == fsbr_pkg::TX_HD1);

    always_comb begin
        pif.hi[`FSBR_CH_TX]    = tx_sub2 ? st.tx_attr[`FSBR_ADDR_HI:`FSBR_HI_GRP_LO]
                                         : tx_addr_m[`FSBR_ADDR_HI:`FSBR_HI_GRP_LO];
        pif.lo[`FSBR_CH_TX]    = tx_sub2 ? {st.tx_attr[`FSBR_HI_GRP_LO-1:`FSBR_ADDR_LO],
                                            st.tx_req_b}
                                         : {tx_addr_m[`FSBR_HI_GRP_LO-1:`FSBR_ADDR_LO],
                                            tx_req_a};
        pif.sub2[`FSBR_CH_TX]  = tx_sub2;
        pif.hi[`FSBR_CH_RX1]   = st.rx_addr[`FSBR_ADDR_HI:`FSBR_HI_GRP_LO];
        pif.lo[`FSBR_CH_RX1]   = {st.rx_addr[`FSBR_HI_GRP_LO-1:`FSBR_ADDR_LO], st.rx_req_a};
        pif.sub2[`FSBR_CH_RX1] = 1'b0;
        pif.hi[`FSBR_CH_RX2]   = st.rx_attr[`FSBR_ADDR_HI:`FSBR_HI_GRP_LO];
        pif.lo[`FSBR_CH_RX2]   = {st.rx_attr[`FSBR_HI_GRP_LO-1:`FSBR_ADDR_LO], st.rx_req_b};
        pif.sub2[`FSBR_CH_RX2] = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // edge detection on synchronised pins (second stage and its delay only)

    assign stb_fall = st.stb_d & ~st.stb_s2;
    assign stb_rise = ~st.stb_d & st.stb_s2;
    assign ads_fall = st.ads_d & ~st.ads_s2;
    assign a_now    = ~st.a_s2;
    assign req_now  = ~st.req_s2;

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        next_st = st;
        next_st.a20_s1 = addr_bit20_mask_in_n;
        next_st.a20_s2 = st.a20_s1;
        next_st.ads_s1 = address_valid_strobe_n_pin;
        next_st.ads_s2 = st.ads_s1;
        next_st.ads_d  = st.ads_s2;
        next_st.stb_s1 = addr_source_strobes_n_pin;
        next_st.stb_s2 = st.stb_s1;
        next_st.stb_d  = st.stb_s2;
        next_st.a_s1   = addr_lines_n_pin;
        next_st.a_s2   = st.a_s1;
        next_st.req_s1 = req_type_n_pin;
        next_st.req_s2 = st.req_s1;
        next_st.ap_s1  = address_parity_pair_n_pin;
        next_st.ap_s2  = st.ap_s1;
        // far end keeps the mask steady around target-ready of an io write
        next_st.a20_mask  = ~st.a20_s2;
        next_st.rx_start  = 1'b0;
        next_st.rx_valid  = 1'b0;
        next_st.par_err   = 1'b0;
        next_st.proto_err = 1'b0;
        next_st.fin       = 1'b0;
        next_st.cnt       = st.cnt - 8'h01;

        // transmit sequencer
        unique case (st.tx)
            fsbr_pkg::TX_IDLE: begin
                next_st.cnt = HALF;
                if (tx_valid) begin
                    next_st.tx       = fsbr_pkg::TX_SU1;
                    next_st.tx_attr  = tx_attr;
                    next_st.tx_req_b = tx_req_b;
                    next_st.a_drv    = ~tx_addr_m;
                    next_st.req_drv  = ~tx_req_a;
                    next_st.ap_drv   = pif.ap[`FSBR_CH_TX];
                    next_st.ads_drv  = 1'b0; // strobe with the address
                    next_st.stb_drv  = 2'b11;
                    next_st.oe_n     = 1'b0;
                end
            end
            fsbr_pkg::TX_SU1: begin
                if (st.cnt == 8'h01) begin
                    next_st.tx      = fsbr_pkg::TX_HD1;
                    next_st.cnt     = HALF;
                    next_st.stb_drv = 2'b00; // falling edge carries sub-phase 1
                end
            end
            fsbr_pkg::TX_HD1: begin
                if (st.cnt == 8'h01) begin
                    next_st.tx      = fsbr_pkg::TX_SU2;
                    next_st.cnt     = HALF;
                    next_st.ads_drv = 1'b1;
                    next_st.a_drv   = ~st.tx_attr;
                    next_st.req_drv = ~st.tx_req_b;
                    next_st.ap_drv  = pif.ap[`FSBR_CH_TX];
                end
            end
            fsbr_pkg::TX_SU2: begin
                if (st.cnt == 8'h01) begin
                    next_st.tx      = fsbr_pkg::TX_HD2;
                    next_st.cnt     = HALF;
                    next_st.stb_drv = 2'b11; // rising edge carries sub-phase 2
                end
            end
            fsbr_pkg::TX_HD2: begin
                if (st.cnt == 8'h01) begin
                    next_st.tx   = fsbr_pkg::TX_IDLE;
                    next_st.oe_n = 1'b1;
                end
            end
        endcase

        // receive path; own transactions are not looked at
        if (st.tx == fsbr_pkg::TX_IDLE) begin
            if (ads_fall) begin
                next_st.rx_start  = 1'b1; // new transaction seen
                next_st.proto_err = st.rx_busy;
                next_st.rx_busy   = 1'b1;
                next_st.got_f     = 2'b00;
                next_st.got_r     = 2'b00;
            end else if (|stb_fall && !st.rx_busy) begin
                next_st.proto_err = 1'b1; // strobe without an address strobe
            end
            if (st.rx_busy) begin
                if (stb_fall[0]) begin
                    // strobe 0 group, sub-phase 1
                    next_st.rx_req_a = req_now;
                    next_st.rx_addr[16:3]  = a_now[16:3];
                    next_st.rx_addr[37:36] = a_now[37:36];
                    next_st.ap_rx1 = st.ap_s2;
                    next_st.got_f[0] = 1'b1;
                end
                if (stb_fall[1]) begin
                    next_st.rx_addr[35:17] = a_now[35:17];
                    next_st.got_f[1] = 1'b1;
                end
                if (stb_rise[0] && st.got_f[0]) begin
                    // strobe 0 group, sub-phase 2
                    next_st.rx_req_b = req_now;
                    next_st.rx_attr[16:3]  = a_now[16:3];
                    next_st.rx_attr[37:36] = a_now[37:36];
                    next_st.ap_rx2 = st.ap_s2;
                    next_st.got_r[0] = 1'b1;
                end
                if (stb_rise[1] && st.got_f[1]) begin
                    next_st.rx_attr[35:17] = a_now[35:17];
                    next_st.got_r[1] = 1'b1;
                end
                if ((next_st.got_r == 2'b11) && !ads_fall) begin
                    next_st.rx_busy = 1'b0;
                    next_st.fin     = 1'b1;
                end
            end
        end
        if (st.fin) begin
            next_st.rx_valid = 1'b1;
            // both sub-phases checked against the received parity pair
            next_st.par_err  = (pif.ap[`FSBR_CH_RX1] != st.ap_rx1)
                             | (pif.ap[`FSBR_CH_RX2] != st.ap_rx2);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st          <= '0;
            st.ads_s1   <= 1'b1;
            st.ads_s2   <= 1'b1;
            st.ads_d    <= 1'b1;
            st.stb_s1   <= 2'b11;
            st.stb_s2   <= 2'b11;
            st.stb_d    <= 2'b11;
            st.a20_s1   <= 1'b1;
            st.a20_s2   <= 1'b1;
            st.tx       <= fsbr_pkg::TX_IDLE;
            st.a_drv    <= '1;
            st.req_drv  <= '1;
            st.ap_drv   <= 2'b11;
            st.ads_drv  <= 1'b1;
            st.stb_drv  <= 2'b11;
            st.oe_n     <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign addr_lines_n_drv           = st.a_drv;
    assign addr_lines_oe_n            = st.oe_n;
    assign req_type_n_drv             = st.req_drv;
    assign req_type_oe_n              = st.oe_n;
    assign address_valid_strobe_n_drv = st.ads_drv;
    assign address_valid_strobe_oe_n  = st.oe_n;
    assign addr_source_strobes_n_drv  = st.stb_drv;
    assign addr_source_strobes_oe_n   = st.oe_n;
    assign address_parity_pair_n_drv  = st.ap_drv;
    assign address_parity_pair_oe_n   = st.oe_n;
    assign tx_ready                   = (st.tx == fsbr_pkg::TX_IDLE);
    assign rx_start                   = st.rx_start;
    assign rx_valid                   = st.rx_valid;
    assign rx_addr                    = st.rx_addr;
    assign rx_attr                    = st.rx_attr;
    assign rx_req_a                   = st.rx_req_a;
    assign rx_req_b                   = st.rx_req_b;
    assign rx_parity_err              = st.par_err;
    assign rx_protocol_err            = st.proto_err;
    assign a20_mask_active            = st.a20_mask;

endmodule : fsbr_addr_req

`default_nettype wire

// [inc/fsbr_defines.svh]
// constants for the front side bus address request phase block
// assumes a 250 MHz system clock and a bench strobe period of 160 ns
`ifndef FSBR_DEFINES_SVH
`define FSBR_DEFINES_SVH

`define FSBR_CLK_NS        4
`define FSBR_ADSTB_HALF_NS 80
// least time, rounded up to whole cycles
`define FSBR_HALF_CYC      ((`FSBR_ADSTB_HALF_NS + `FSBR_CLK_NS - 1) / `FSBR_CLK_NS)
`define FSBR_ADDR_HI       37
`define FSBR_ADDR_LO       3
`define FSBR_HI_GRP_LO     24
`define FSBR_A20_BIT       20
`define FSBR_REQ_W         5
`define FSBR_PAR_CH        3
`define FSBR_CH_TX         0
`define FSBR_CH_RX1        1
`define FSBR_CH_RX2        2

`endif

// [inc/fsbr_pkg.sv]
// types for the front side bus address request phase block
// assumes fsbr_defines.svh for widths
`include "fsbr_defines.svh"

package fsbr_pkg;

    typedef enum logic [2:0] {
        TX_IDLE,
        TX_SU1,
        TX_HD1,
        TX_SU2,
        TX_HD2
    } fsbr_tx_e;

    typedef logic [`FSBR_ADDR_HI:`FSBR_ADDR_LO] fsbr_addr_t;
    typedef logic [`FSBR_REQ_W-1:0]             fsbr_req_t;

    typedef struct packed {
        logic       a20_s1;
        logic       a20_s2;
        logic       ads_s1;
        logic       ads_s2;
        logic       ads_d;
        logic [1:0] stb_s1;
        logic [1:0] stb_s2;
        logic [1:0] stb_d;
        fsbr_addr_t a_s1;
        fsbr_addr_t a_s2;
        fsbr_req_t  req_s1;
        fsbr_req_t  req_s2;
        logic [1:0] ap_s1;
        logic [1:0] ap_s2;
        fsbr_tx_e   tx;
        logic [7:0] cnt;
        fsbr_addr_t tx_attr;
        fsbr_req_t  tx_req_b;
        fsbr_addr_t a_drv;
        fsbr_req_t  req_drv;
        logic [1:0] ap_drv;
        logic       ads_drv;
        logic [1:0] stb_drv;
        logic       oe_n;
        logic       rx_busy;
        logic [1:0] got_f;
        logic [1:0] got_r;
        logic       fin;
        logic [1:0] ap_rx1;
        logic [1:0] ap_rx2;
        fsbr_addr_t rx_addr;
        fsbr_addr_t rx_attr;
        fsbr_req_t  rx_req_a;
        fsbr_req_t  rx_req_b;
        logic       rx_start;
        logic       rx_valid;
        logic       par_err;
        logic       proto_err;
        logic       a20_mask;
    } fsbr_state_s;

endpackage : fsbr_pkg

// [inc/fsbr_par_if.sv]
// carrier between the request phase block and its parity calculator
// assumes fsbr_defines.svh; groups are asserted-high values
`timescale 1ns/1ps
`default_nettype none
`include "fsbr_defines.svh"

interface fsbr_par_if #(
    parameter int N = `FSBR_PAR_CH
);
    logic [13:0] hi   [N];
    logic [25:0] lo   [N];
    logic        sub2 [N];
    logic [1:0]  ap   [N];

    modport calc (input hi, input lo, input sub2, output ap);
    modport user (output hi, output lo, output sub2, input ap);
endinterface : fsbr_par_if

`default_nettype wire

// [rtl/fsbr_parity_calc.sv]
// address parity pair generator, one lane per channel
// assumes asserted-high inputs; outputs are pin levels of the parity pair
`timescale 1ns/1ps
`default_nettype none

module fsbr_parity_calc #(
    parameter int N = 3
) (
    fsbr_par_if.calc pif
);
    generate
        if (N < 1) begin : g_chk
            $error("fsbr_parity_calc needs at least one channel");
        end
        for (genvar i = 0; i < N; i++) begin : g_ch
            logic p_hi;
            logic p_lo;
            // pin high when an even number of covered pins are low
            assign p_hi = ~^pif.hi[i];
            assign p_lo = ~^pif.lo[i];
            // parity bits swap coverage in the second sub-phase
            assign pif.ap[i] = pif.sub2[i] ? {p_hi, p_lo} : {p_lo, p_hi};
        end
    endgenerate
endmodule : fsbr_parity_calc

`default_nettype wire

// [tb/fsbr_addr_req_props.sv]
// checker for the address request phase block, bound to its top module
// assumes only the block's ports; one clock domain with a synchronous reset
`timescale 1ns/1ps
`default_nettype none

module fsbr_addr_req_props #(
    parameter int HALF_CYC = 20
) (
    input wire logic                 clk_sys,
    input wire logic                 srst,
    input wire fsbr_pkg::fsbr_addr_t addr_lines_n_drv,
    input wire logic                 addr_lines_oe_n,
    input wire fsbr_pkg::fsbr_req_t  req_type_n_drv,
    input wire logic                 address_valid_strobe_n_pin,
    input wire logic                 address_valid_strobe_n_drv,
    input wire logic                 address_valid_strobe_oe_n,
    input wire logic [1:0]           addr_source_strobes_n_drv,
    input wire logic [1:0]           address_parity_pair_n_drv,
    input wire logic                 addr_bit20_mask_in_n,
    input wire logic                 tx_valid,
    input wire logic                 tx_ready,
    input wire logic                 rx_start,
    input wire logic                 rx_valid,
    input wire logic                 rx_parity_err,
    input wire logic                 a20_mask_active
);
    logic [15:0] low_cnt;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    ////////////////////////////////////////
    // cycles the address strobe has been driven low
    always_ff @(posedge clk_sys) begin
        if (srst || address_valid_strobe_n_drv) begin
            low_cnt <= 16'h0000;
        end else begin
            low_cnt <= low_cnt + 16'h0001;
        end
    end

    a_take_answer: assert property (
        tx_valid && tx_ready |=> !address_valid_strobe_n_drv && !addr_lines_oe_n && !tx_ready)
        else $error("request not answered on the next cycle");
    a_ads_lines_valid: assert property (
        !address_valid_strobe_n_drv |-> !addr_lines_oe_n && !address_valid_strobe_oe_n)
        else $error("address strobe low without driven lines");
    a_ads_span: assert property (
        $rose(address_valid_strobe_n_drv) |-> low_cnt == 2 * HALF_CYC)
        else $error("address strobe low for a wrong count");
    a_strobe_fall: assert property (
        $fell(addr_source_strobes_n_drv[0]) |->
            addr_source_strobes_n_drv == 2'b00 && low_cnt == HALF_CYC)
        else $error("source strobes fell apart or at a wrong time");
    a_strobe_rise: assert property (
        $rose(addr_source_strobes_n_drv[0]) |->
            addr_source_strobes_n_drv == 2'b11 && address_valid_strobe_n_drv && !addr_lines_oe_n)
        else $error("source strobes rose outside sub-phase 2");
    // both groups have even widths, so an even count of low pins means even xor of pin levels
    a_par_sub1: assert property (
        !addr_lines_oe_n && !address_valid_strobe_n_drv |-> address_parity_pair_n_drv ==
            {~^{addr_lines_n_drv[23:3], req_type_n_drv}, ~^addr_lines_n_drv[37:24]})
        else $error("parity pair wrong in sub-phase 1");
    a_par_sub2: assert property (
        !addr_lines_oe_n && address_valid_strobe_n_drv |-> address_parity_pair_n_drv ==
            {~^addr_lines_n_drv[37:24], ~^{addr_lines_n_drv[23:3], req_type_n_drv}})
        else $error("parity pair wrong in sub-phase 2");
    a_mask_rise: assert property (
        $fell(addr_bit20_mask_in_n) |-> ##[2:3] a20_mask_active)
        else $error("mask input not seen in time");
    a_mask_clear: assert property (
        tx_valid && tx_ready && a20_mask_active |=> addr_lines_n_drv[20])
        else $error("address bit 20 driven while masked");
    a_start_cause: assert property (
        $fell(address_valid_strobe_n_pin) && addr_lines_oe_n |-> ##[2:6] rx_start)
        else $error("foreign address strobe not reported");
    a_err_with_valid: assert property (
        rx_parity_err |-> rx_valid)
        else $error("parity error flagged outside a completion");
endmodule : fsbr_addr_req_props

bind fsbr_addr_req fsbr_addr_req_props #(.HALF_CYC(HALF_CYC)) u_props (
    .clk_sys, .srst, .addr_lines_n_drv, .addr_lines_oe_n, .req_type_n_drv,
    .address_valid_strobe_n_pin, .address_valid_strobe_n_drv, .address_valid_strobe_oe_n,
    .addr_source_strobes_n_drv, .address_parity_pair_n_drv, .addr_bit20_mask_in_n,
    .tx_valid, .tx_ready, .rx_start, .rx_valid, .rx_parity_err, .a20_mask_active
);

`default_nettype wire

// [tb/fsbr_far_agent.sv]
// far bus agent: issues request phases on the shared address pins
// assumes released lines are pulled up, so idle is all ones
`timescale 1ns/1ps
`default_nettype none

module fsbr_far_agent (
    output var fsbr_pkg::fsbr_addr_t a_n,
    output var fsbr_pkg::fsbr_req_t  req_n,
    output var logic                 ads_n,
    output var logic [1:0]           stb_n,
    output var logic [1:0]           ap_n
);
    initial begin
        a_n   = '1;
        req_n = '1;
        ads_n = 1'b1;
        stb_n = 2'b11;
        ap_n  = 2'b11;
    end

    ////////////////////////////////////////
    // pin levels of the parity pair; sub-phase 2 swaps the halves
    function automatic logic [1:0] par(input fsbr_pkg::fsbr_addr_t a,
                                       input fsbr_pkg::fsbr_req_t r, input logic sub2);
        logic hi;
        logic lo;
        hi = ~^a[37:24]; // high on an even count of low pins
        lo = ~^{a[23:3], r};
        return sub2 ? {hi, lo} : {lo, hi};
    endfunction : par

    task automatic send(input fsbr_pkg::fsbr_addr_t a, input fsbr_pkg::fsbr_req_t ra,
                        input fsbr_pkg::fsbr_addr_t t, input fsbr_pkg::fsbr_req_t rb,
                        input int half, input logic bad);
        #1;
        ads_n = 1'b0;
        a_n   = ~a;
        req_n = ~ra;
        ap_n  = par(a, ra, 1'b0) ^ {1'b0, bad};
        #(half);
        stb_n = 2'b00; // falling edges carry sub-phase 1
        #(half / 2);
        ads_n = 1'b1;
        a_n   = ~t;
        req_n = ~rb;
        ap_n  = par(t, rb, 1'b1);
        #(half / 2);
        stb_n = 2'b11; // rising edges carry sub-phase 2
        #(half);
        a_n   = '1;
        req_n = '1;
        ap_n  = 2'b11;
    endtask : send

    // strobe pulse with no address strobe ahead of it
    task automatic stray();
        #1;
        stb_n = 2'b00;
        #80;
        stb_n = 2'b11;
        #80;
    endtask : stray
endmodule : fsbr_far_agent

`default_nettype wire

// [tb/fsbr_addr_req_tb_top.sv]
// self-checking bench for the address request phase block
// assumes the far agent model and the bound checker are compiled with it
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin errors++; \
    $display("BAD t=%0t got=%0h exp=%0h", $time, (g), (e)); end end

module fsbr_addr_req_tb_top;
    localparam int H = 20;
    logic                 clk_sys = 1'b0, srst = 1'b1, tx_valid = 1'b0;
    logic                 addr_bit20_mask_in_n = 1'b1;
    fsbr_pkg::fsbr_addr_t tx_addr = '0, tx_attr = '0, addr_lines_n_pin, addr_lines_n_drv;
    fsbr_pkg::fsbr_addr_t rx_addr, rx_attr, p_a;
    fsbr_pkg::fsbr_req_t  tx_req_a = '0, tx_req_b = '0, req_type_n_pin, req_type_n_drv;
    fsbr_pkg::fsbr_req_t  rx_req_a, rx_req_b, p_req;
    logic [1:0]           addr_source_strobes_n_pin, addr_source_strobes_n_drv, p_stb;
    logic [1:0]           address_parity_pair_n_pin, address_parity_pair_n_drv, p_ap;
    logic                 address_valid_strobe_n_pin, address_valid_strobe_n_drv, p_ads;
    logic                 addr_lines_oe_n, req_type_oe_n, address_valid_strobe_oe_n;
    logic                 addr_source_strobes_oe_n, address_parity_pair_oe_n, tx_ready;
    logic                 rx_start, rx_valid, rx_parity_err, rx_protocol_err, a20_mask_active;
    int                   errors = 0, tests_run = 0, cyc = 0;

    // each wire is low when any party pulls it low
    assign addr_lines_n_pin = (addr_lines_oe_n ? '1 : addr_lines_n_drv) & p_a;
    assign req_type_n_pin = (req_type_oe_n ? '1 : req_type_n_drv) & p_req;
    assign address_valid_strobe_n_pin =
        (address_valid_strobe_oe_n ? 1'b1 : address_valid_strobe_n_drv) & p_ads;
    assign addr_source_strobes_n_pin =
        (addr_source_strobes_oe_n ? 2'b11 : addr_source_strobes_n_drv) & p_stb;
    assign address_parity_pair_n_pin =
        (address_parity_pair_oe_n ? 2'b11 : address_parity_pair_n_drv) & p_ap;

    fsbr_addr_req #(.HALF_CYC(H)) dut (
        .clk_sys, .srst, .addr_lines_n_pin, .addr_lines_n_drv, .addr_lines_oe_n,
        .req_type_n_pin, .req_type_n_drv, .req_type_oe_n, .address_valid_strobe_n_pin,
        .address_valid_strobe_n_drv, .address_valid_strobe_oe_n, .addr_source_strobes_n_pin,
        .addr_source_strobes_n_drv, .addr_source_strobes_oe_n, .address_parity_pair_n_pin,
        .address_parity_pair_n_drv, .address_parity_pair_oe_n, .addr_bit20_mask_in_n,
        .tx_valid, .tx_ready, .tx_addr, .tx_attr, .tx_req_a, .tx_req_b, .rx_start, .rx_valid,
        .rx_addr, .rx_attr, .rx_req_a, .rx_req_b, .rx_parity_err, .rx_protocol_err,
        .a20_mask_active
    );
    fsbr_far_agent far (.a_n(p_a), .req_n(p_req), .ads_n(p_ads), .stb_n(p_stb), .ap_n(p_ap));

    ////////////////////////////////////////
    always #2 clk_sys = ~clk_sys;

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            errors++;
            final_report();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick

    task automatic final_report();
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report

    // returns in sub-phase 2, so a following call is taken back to back
    task automatic t_tx(input fsbr_pkg::fsbr_addr_t a, input fsbr_pkg::fsbr_addr_t t,
                        input fsbr_pkg::fsbr_req_t ra, input fsbr_pkg::fsbr_req_t rb);
        fsbr_pkg::fsbr_addr_t ea;
        ea = a;
        ea[20] = a[20] & addr_bit20_mask_in_n;
        tx_addr = a;
        tx_attr = t;
        tx_req_a = ra;
        tx_req_b = rb;
        tx_valid = 1'b1;
        for (int i = 0; i < 200 && tx_ready !== 1'b1; i++) tick(1);
        tick(1);
        tx_valid = 1'b0;
        tick(H / 2);
        `CHK(address_valid_strobe_n_drv, 1'b0);
        `CHK({req_type_oe_n, addr_source_strobes_oe_n, address_parity_pair_oe_n}, 3'h0);
        `CHK(addr_lines_n_drv, ~ea);
        `CHK(req_type_n_drv, ~ra);
        `CHK(address_parity_pair_n_drv, far.par(ea, ra, 1'b0));
        tick(2 * H);
        `CHK({address_valid_strobe_n_drv, addr_source_strobes_n_drv}, 3'h4);
        `CHK(addr_lines_n_drv, ~t);
        `CHK(req_type_n_drv, ~rb);
        `CHK(address_parity_pair_n_drv, far.par(t, rb, 1'b1));
    endtask : t_tx

    task automatic t_mask();
        addr_bit20_mask_in_n = 1'b0; // held until t_tx returns in sub-phase 2
        tick(5);
        `CHK(a20_mask_active, 1'b1);
        t_tx(35'h7_FFFF_FFFF, 35'h0_1234_5678, 5'h1F, 5'h11);
        addr_bit20_mask_in_n = 1'b1;
        tick(2 * H + 5);
        `CHK({a20_mask_active, addr_lines_oe_n, tx_ready}, 3'h3);
    endtask : t_mask

    task automatic t_rx(input fsbr_pkg::fsbr_addr_t a, input fsbr_pkg::fsbr_addr_t t,
                        input fsbr_pkg::fsbr_req_t ra, input fsbr_pkg::fsbr_req_t rb,
                        input int half, input logic bad);
        logic seen;
        logic vld;
        logic perr;
        seen = 1'b0;
        fork
            far.send(a, ra, t, rb, half, bad);
            begin
                for (int i = 0; i < 300 && rx_valid !== 1'b1; i++) begin
                    @(posedge clk_sys);
                    seen = seen | (rx_start === 1'b1);
                end
                vld = rx_valid;
                perr = rx_parity_err;
            end
        join
        `CHK(seen, 1'b1);
        `CHK({vld, perr}, {1'b1, bad});
        `CHK({rx_addr, rx_req_a}, {a, ra});
        `CHK({rx_attr, rx_req_b}, {t, rb});
        tick(3);
    endtask : t_rx

    task automatic t_stray();
        logic perr;
        logic vld;
        perr = 1'b0;
        vld = 1'b0;
        fork
            far.stray();
            repeat (60) begin
                @(posedge clk_sys);
                perr = perr | (rx_protocol_err === 1'b1);
                vld = vld | (rx_valid === 1'b1);
            end
        join
        `CHK({perr, vld}, 2'b10);
        tick(3);
    endtask : t_stray

    initial begin
        repeat (10) @(posedge clk_sys);
        #1;
        srst = 1'b0;
        tick(3);
        `CHK({tx_ready, addr_lines_oe_n, address_valid_strobe_n_drv, a20_mask_active}, 4'hE);
        `CHK(rx_addr, 35'h0_0000_0000);
        t_tx(35'h7_1234_5678, 35'h0_0F0F_00FF, 5'h15, 5'h0A);
        t_tx(35'h0_0000_0001, 35'h7_FFFF_FFFF, 5'h00, 5'h1F);
        t_mask();
        t_rx(35'h5_5555_5555, 35'h2_AAAA_AAAA, 5'h03, 5'h1C, 80, 1'b0);
        t_rx(35'h1_8000_0007, 35'h6_0F0F_F0F0, 5'h1E, 5'h01, 123, 1'b0);
        t_rx(35'h3_C3C3_3C3C, 35'h0_0000_0000, 5'h0B, 5'h14, 80, 1'b1);
        t_stray();
        final_report();
    end
endmodule : fsbr_addr_req_tb_top

`undef CHK
`default_nettype wire
